// ===== cmvm_chip_mode_vector_map.v
// Purpose: latch the operating mode after reset and map reset and
//          interrupt sources onto vector addresses for the core
// Assumes: single clock at 100 MHz; core inputs are on that clock;
//          boot and debug pins are asynchronous
// Notes:   registers on classic Wishbone, one word each
`include "cmvm_defs.vh"
module cmvm_chip_mode_vector_map #(
  parameter NSRC = 7                  // number of interrupt sources
) (
  input  wire        clock,           // system clock
  input  wire        rst,             // async reset, high
  // wishbone slave
  input  wire        wb_cyc_i,        // bus cycle
  input  wire        wb_stb_i,        // strobe
  input  wire        wb_we_i,         // write enable
  input  wire [7:0]  wb_adr_i,        // byte address
  input  wire [3:0]  wb_sel_i,        // byte selects
  input  wire [31:0] wb_dat_i,        // write data
  output reg  [31:0] wb_dat_o,        // read data
  output wire        wb_ack_o,        // acknowledge
  output wire        irqOut,          // level interrupt
  // pins
  input  wire        bootModeSelect,  // boot mode strap
  input  wire        debugPinIn,      // single debug pin level
  // reset sources, levels from reset controller
  input  wire        clkMonRst,       // clock monitor reset cause
  input  wire        wdogRst,         // watchdog reset cause
  // security and flash
  input  wire        securedIn,       // device secured
  input  wire        flashAccReq,     // debug flash access request
  output reg         flashBlock_ff,   // flash access refused
  // core side
  input  wire        iBit,            // core I mask
  input  wire        xBit,            // core X mask
  input  wire        stopMode,        // core in stop
  input  wire        waitMode,        // core in wait
  input  wire        vecReq,          // vector fetch request
  input  wire        vecIsReset,      // fetch is a reset fetch
  output reg         vecAck_ff,       // vector valid pulse
  output reg  [15:0] vecAddr_ff,      // vector address
  output reg         bdmActive_ff,    // debug unit active
  output reg         monitorRom_ff,   // run monitor from ROM
  output reg         debugEn_ff,      // debug features on
  output reg         wakeStop_ff,     // wake from stop
  output reg         wakeWait_ff,     // wake from wait
  // request sources
  input  wire        trapReq,         // unimplemented trap
  input  wire        swiReq,          // software interrupt
  input  wire        xirqReq,         // nonmaskable pin
  input  wire        irqReq,          // maskable pin
  input  wire        paOvfReq,        // pulse acc overflow
  input  wire        paEdgeReq,       // pulse acc edge
  input  wire [3:0]  uartReq          // uart flags
);
  // ========================================================
  // state codes
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_CHECK = 3'b010;
  localparam [2:0] ST_DONE  = 3'b100;

  reg         ack_ff;
  reg         mode_ff;
  reg  [7:0]  vecBase_ff;
  reg  [9:0]  enables_ff;
  reg  [3:0]  status_ff;
  reg  [3:0]  mask_ff;
  reg  [2:0]  bootSync_ff;
  reg  [2:0]  dbgSync_ff;
  reg         dbgLevel_ff;
  reg  [1:0]  captCnt_ff;
  reg         captDone_ff;
  reg  [2:0]  state_ff;
  reg  [2:0]  winner_ff;
  reg         hit_ff;
  reg  [2:0]  nxt_state;
  reg  [3:0]  nxt_status;
  reg  [3:0]  evSet;
  reg  [15:0] nxt_vec;
  reg         spurNow;
  reg  [31:0] byteMask;
  reg  [2:0]  pick;
  reg         anyPend;
  reg         pd;
  integer     k;
  wire [NSRC-1:0] pend;
  wire [NSRC-1:0] stopAble;
  wire        busWr;
  wire        busRd;
  wire [2:0]  wdRate;
  wire [3:0]  uartEn;

  assign wdRate = enables_ff[`CMVM_WDR_MSB:`CMVM_WDR_LSB];
  assign uartEn = enables_ff[`CMVM_UART_MSB:`CMVM_UART_LSB];

  // ========================================================
  // fixed offset per source, index 0 highest priority
  function [7:0] srcOffset;
    input [2:0] idx;
    begin
      case (idx)
        3'h0: srcOffset = `CMVM_OFF_TRAP;
        3'h1: srcOffset = `CMVM_OFF_SWI;
        3'h2: srcOffset = `CMVM_OFF_XIRQ;
        3'h3: srcOffset = `CMVM_OFF_IRQ;
        3'h4: srcOffset = `CMVM_OFF_PAOVF;
        3'h5: srcOffset = `CMVM_OFF_PAEDGE;
        3'h6: srcOffset = `CMVM_OFF_UART;
        default: srcOffset = `CMVM_OFF_SPUR;
      endcase
    end
  endfunction

  // ========================================================
  // request gating: masks and local enables per source
  genvar g;
  generate
    for (g = 0; g < NSRC; g = g + 1) begin : gSrc
      if (g == 0) begin : gTrap
        assign pend[g]     = trapReq;
        assign stopAble[g] = 1'b0;
      end else if (g == 1) begin : gSwi
        assign pend[g]     = swiReq;
        assign stopAble[g] = 1'b0;
      end else if (g == 2) begin : gXirq
        assign pend[g]     = xirqReq & ~xBit;
        assign stopAble[g] = 1'b1;
      end else if (g == 3) begin : gIrq
        assign pend[g]     = irqReq & ~iBit;
        assign stopAble[g] = 1'b1;
      end else if (g == 4) begin : gPaOvf
        assign pend[g]     = paOvfReq & ~iBit &
                             enables_ff[`CMVM_PAOVF_BIT];
        assign stopAble[g] = 1'b0;
      end else if (g == 5) begin : gPaEdge
        assign pend[g]     = paEdgeReq & ~iBit &
                             enables_ff[`CMVM_PAEDGE_BIT];
        assign stopAble[g] = 1'b0;
      end else begin : gUart
        assign pend[g]     = (|(uartReq & uartEn)) & ~iBit;
        assign stopAble[g] = 1'b1;
      end
    end
  endgenerate

  // priority pick: lowest index is the highest offset
  always @* begin
    pick    = 3'h7;
    anyPend = 1'b0;
    for (k = NSRC - 1; k >= 0; k = k - 1) begin
      if (pend[k]) begin
        pick    = k[2:0];
        anyPend = 1'b1;
      end
    end
  end

  // ========================================================
  // pin synchronisers, three stages each
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      bootSync_ff <= 3'h0;
      // debug pin idles high; a low start would show a false low level
      dbgSync_ff  <= 3'h7;
      dbgLevel_ff <= 1'b1;
    end else begin
      bootSync_ff <= {bootSync_ff[1:0], bootModeSelect};
      dbgSync_ff  <= {dbgSync_ff[1:0], debugPinIn};
      if (dbgSync_ff[1] == dbgSync_ff[2]) begin
        dbgLevel_ff <= dbgSync_ff[2];
      end
    end
  end

  // ========================================================
  // wishbone slave: one wait state, ack drops after one cycle
  assign busWr    = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_ff;
  assign busRd    = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_ff;
  assign wb_ack_o = ack_ff;

  always @* begin
    byteMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  end

  // read mux; unmapped addresses read zero
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_ff   <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
      if (busRd) begin
        if (wb_adr_i == `CMVM_OFS_MODE) begin
          wb_dat_o <= {28'h0, dbgLevel_ff, securedIn,
                       bdmActive_ff, mode_ff};
        end else if (wb_adr_i == `CMVM_OFS_VECBASE) begin
          wb_dat_o <= {24'h0, vecBase_ff};
        end else if (wb_adr_i == `CMVM_OFS_ENABLES) begin
          wb_dat_o <= {22'h0, enables_ff};
        end else if (wb_adr_i == `CMVM_OFS_STATUS) begin
          wb_dat_o <= {28'h0, status_ff};
        end else if (wb_adr_i == `CMVM_OFS_MASK) begin
          wb_dat_o <= {28'h0, mask_ff};
        end else if (wb_adr_i == `CMVM_OFS_LASTVEC) begin
          wb_dat_o <= {16'h0, vecAddr_ff};
        end else begin
          wb_dat_o <= 32'h0;
        end
      end
    end
  end

  // ========================================================
  // mode capture after release, then limited software change;
  // capture waits for the sync chain to fill and agree
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_ff     <= `CMVM_RST_MODE;
      captCnt_ff  <= 2'h0;
      captDone_ff <= 1'b0;
    end else if (!captDone_ff) begin
      if (captCnt_ff != `CMVM_CAPT_CYC) begin
        captCnt_ff <= captCnt_ff + 2'h1;
      end else if (bootSync_ff[1] == bootSync_ff[2]) begin
        mode_ff     <= bootSync_ff[2];
        captDone_ff <= 1'b1;
      end
    end else if (busWr && wb_sel_i[0] &&
                 wb_adr_i == `CMVM_OFS_MODE) begin
      // only special to normal; the reverse would bypass security
      if (!mode_ff && wb_dat_i[`CMVM_MODE_BIT]) begin
        mode_ff <= 1'b1;
      end
    end
  end

  // ========================================================
  // control registers with byte lanes
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      vecBase_ff <= `CMVM_RST_VECBASE;
      enables_ff <= `CMVM_RST_ENABLES;
      mask_ff    <= `CMVM_RST_MASK;
    end else if (busWr) begin
      if (wb_adr_i == `CMVM_OFS_VECBASE) begin
        vecBase_ff <= (vecBase_ff & ~byteMask[7:0]) |
                      (wb_dat_i[7:0] & byteMask[7:0]);
      end else if (wb_adr_i == `CMVM_OFS_ENABLES) begin
        enables_ff <= (enables_ff & ~byteMask[9:0]) |
                      (wb_dat_i[9:0] & byteMask[9:0]);
      end else if (wb_adr_i == `CMVM_OFS_MASK) begin
        mask_ff <= (mask_ff & ~byteMask[3:0]) |
                   (wb_dat_i[3:0] & byteMask[3:0]);
      end
    end
  end

  // ========================================================
  // vector fetch sequence
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:  if (vecReq) nxt_state = ST_CHECK;
      ST_CHECK: nxt_state = ST_DONE;
      ST_DONE:  if (!vecReq) nxt_state = ST_IDLE;
      default:  nxt_state = ST_IDLE;
    endcase
  end

  // vector choice in the check cycle
  always @* begin
    pd      = pend[winner_ff];
    spurNow = 1'b0;
    if (vecIsReset) begin
      if (clkMonRst && enables_ff[`CMVM_OSCEN_BIT]) begin
        nxt_vec = `CMVM_VEC_CLKMON;
      end else if (wdogRst && (wdRate != 3'h0)) begin
        nxt_vec = `CMVM_VEC_WDOG;
      end else begin
        nxt_vec = `CMVM_VEC_RESET;
      end
    end else if (hit_ff && pd) begin
      nxt_vec = {vecBase_ff, srcOffset(winner_ff)};
    end else begin
      // nothing pending at the take, or the request went away before the answer
      nxt_vec = {vecBase_ff, `CMVM_OFF_SPUR};
      spurNow = 1'b1;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff   <= ST_IDLE;
      winner_ff  <= 3'h0;
      hit_ff     <= 1'b0;
      vecAck_ff  <= 1'b0;
      vecAddr_ff <= `CMVM_VEC_RESET;
    end else begin
      state_ff  <= nxt_state;
      vecAck_ff <= 1'b0;
      if (state_ff == ST_IDLE && vecReq) begin
        winner_ff <= pick;
        hit_ff    <= anyPend;
      end
      if (state_ff == ST_CHECK) begin
        vecAddr_ff <= nxt_vec;
        vecAck_ff  <= 1'b1;
      end
    end
  end

  // ========================================================
  // mode, debug, security and wake outputs
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      bdmActive_ff  <= 1'b0;
      monitorRom_ff <= 1'b0;
      debugEn_ff    <= 1'b0;
      flashBlock_ff <= 1'b1;
      wakeStop_ff   <= 1'b0;
      wakeWait_ff   <= 1'b0;
    end else begin
      bdmActive_ff  <= ~mode_ff;
      monitorRom_ff <= ~mode_ff;
      // secured parts keep debug only in special mode
      debugEn_ff    <= ~securedIn | ~mode_ff;
      flashBlock_ff <= securedIn & flashAccReq;
      wakeStop_ff   <= stopMode & (|(pend & stopAble));
      wakeWait_ff   <= waitMode & (|pend[NSRC-1:2]);
    end
  end

  // ========================================================
  // sticky events; a new event beats the clear-on-read
  always @* begin
    evSet = 4'h0;
    evSet[`CMVM_EV_SERVED] = (state_ff == ST_CHECK);
    evSet[`CMVM_EV_SPUR]   = (state_ff == ST_CHECK) & spurNow &
                             ~vecIsReset;
    evSet[`CMVM_EV_WSTOP]  = stopMode & (|(pend & stopAble));
    evSet[`CMVM_EV_WWAIT]  = waitMode & (|pend[NSRC-1:2]);
    nxt_status = status_ff;
    if (busRd && wb_adr_i == `CMVM_OFS_STATUS) begin
      nxt_status = 4'h0;
    end
    nxt_status = nxt_status | evSet;
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      status_ff <= 4'h0;
    end else begin
      status_ff <= nxt_status;
    end
  end

  assign irqOut = |(status_ff & mask_ff);

endmodule

// ===== cmvm_core_model.sv
// Purpose: core model fetching vectors on request
// Assumes: vector handshake of the mode and vector block
// Notes:   holdCyc stretches the request past the answer
module cmvm_core_model (
  input  wire        clock,         // clock
  input  wire        rst,           // reset
  input  wire        fetchGo,       // start fetch
  input  wire        fetchRst,      // reset fetch
  input  wire [3:0]  holdCyc,       // extra hold
  input  wire        vecAck_ff,     // answer
  input  wire [15:0] vecAddr_ff,    // vector
  output reg         vecReq_ff,     // request
  output reg         vecIsReset_ff, // fetch kind
  output reg  [15:0] gotAddr_ff,    // taken vector
  output reg         fetchDone_ff   // fetch over
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [3:0] holdCnt_ff;
  // =====================================================
  // request held to the answer edge plus holdCyc cycles, kind line scrambled when idle
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      vecReq_ff     <= 1'b0;
      vecIsReset_ff <= 1'b0;
      gotAddr_ff    <= 16'h0;
      fetchDone_ff  <= 1'b0;
      holdCnt_ff    <= 4'h0;
    end else if (!vecReq_ff) begin
      if (fetchGo) begin
        vecReq_ff     <= 1'b1;
        vecIsReset_ff <= fetchRst;
        fetchDone_ff  <= 1'b0;
      end
    end else begin
      if (vecAck_ff)
        gotAddr_ff <= vecAddr_ff;
      if (vecAck_ff && holdCyc != 4'h0)
        holdCnt_ff <= holdCyc;
      else if (holdCnt_ff != 4'h0)
        holdCnt_ff <= holdCnt_ff - 4'h1;
      if ((vecAck_ff && holdCyc == 4'h0) || holdCnt_ff == 4'h1) begin
        vecReq_ff     <= 1'b0;
        vecIsReset_ff <= ~vecIsReset_ff; // no stale kind
        fetchDone_ff  <= 1'b1;
      end
    end
  end
endmodule

// ===== cmvm_defs.vh
// Purpose: shared constants for the chip mode and vector map block
// Assumes: byte addresses on a 32-bit classic Wishbone slave
// Notes:   definitions only
`ifndef CMVM_DEFS_VH
`define CMVM_DEFS_VH
// ==========================================================
// register byte offsets
`define CMVM_OFS_MODE      8'h00
`define CMVM_OFS_VECBASE   8'h04
`define CMVM_OFS_ENABLES   8'h08
`define CMVM_OFS_STATUS    8'h0c
`define CMVM_OFS_MASK      8'h10
`define CMVM_OFS_LASTVEC   8'h14
// ==========================================================
// mode register fields
`define CMVM_MODE_BIT      0
`define CMVM_BDM_BIT       1
`define CMVM_SEC_BIT       2
`define CMVM_PIN_BIT       3
// enables register fields
`define CMVM_OSCEN_BIT     0
`define CMVM_WDR_LSB       1
`define CMVM_WDR_MSB       3
`define CMVM_PAOVF_BIT     4
`define CMVM_PAEDGE_BIT    5
`define CMVM_UART_LSB      6
`define CMVM_UART_MSB      9
// status and mask fields
`define CMVM_EV_SERVED     0
`define CMVM_EV_SPUR       1
`define CMVM_EV_WSTOP      2
`define CMVM_EV_WWAIT      3
`define CMVM_EV_W          4
// ==========================================================
// reset values
`define CMVM_RST_MODE      1'b1
`define CMVM_RST_VECBASE   8'hff
`define CMVM_RST_ENABLES   10'h000
`define CMVM_RST_MASK      4'h0
// ==========================================================
// reset vectors and interrupt vector offsets
`define CMVM_VEC_RESET     16'hfffe
`define CMVM_VEC_CLKMON    16'hfffc
`define CMVM_VEC_WDOG      16'hfffa
`define CMVM_OFF_TRAP      8'hf8
`define CMVM_OFF_SWI       8'hf6
`define CMVM_OFF_XIRQ      8'hf4
`define CMVM_OFF_IRQ       8'hf2
`define CMVM_OFF_PAOVF     8'hdc
`define CMVM_OFF_PAEDGE    8'hda
`define CMVM_OFF_UART      8'hd6
`define CMVM_OFF_SPUR      8'h80
// cycles the boot pin chain needs before capture
`define CMVM_CAPT_CYC      2'h3
`endif

// ===== cmvm_props.sv
// Purpose: checker for mode capture, debug gating and vector fetch
// Assumes: one clock, async high reset
// Notes:   sees the block's top ports only
module cmvm_props (
  input wire        clock,          // clock
  input wire        rst,            // reset
  input wire        bootModeSelect, // strap
  input wire        securedIn,      // secured
  input wire        flashAccReq,    // flash req
  input wire        flashBlock_ff,  // flash refused
  input wire        bdmActive_ff,   // debug unit
  input wire        monitorRom_ff,  // monitor rom
  input wire        debugEn_ff,     // debug on
  input wire        vecReq,         // fetch req
  input wire        vecIsReset,     // reset fetch
  input wire        vecAck_ff,      // answer
  input wire [15:0] vecAddr_ff,     // vector
  input wire        clkMonRst,      // clkmon cause
  input wire        wdogRst,        // wdog cause
  input wire        trapReq,        // trap
  input wire        swiReq,         // swi
  input wire        xirqReq,        // xirq
  input wire        irqReq,         // irq
  input wire        iBit,           // i mask
  input wire        xBit,           // x mask
  input wire        stopMode,       // stop
  input wire [3:0]  uartReq,        // uart flags
  input wire        wakeStop_ff     // stop wake
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  reg [3:0] relCnt_ff;
  // =====================================================
  // edges since reset release, saturating
  always @(posedge clock or posedge rst) begin
    if (rst)
      relCnt_ff <= 4'h0;
    else if (relCnt_ff != 4'hf)
      relCnt_ff <= relCnt_ff + 4'h1;
  end
  // =====================================================
  // mode, debug and flash gating
  boot_mode_a: assert property (relCnt_ff == 4'h8 |->
    bdmActive_ff == !bootModeSelect && monitorRom_ff == bdmActive_ff)
    else $error("mode differs from boot pin");
  debug_en_a: assert property (!securedIn |=> debugEn_ff)
    else $error("debug off while unsecured");
  flash_block_a: assert property (securedIn && flashAccReq |=>
    flashBlock_ff) else $error("secured flash access not blocked");
  // =====================================================
  // vector fetch timing and contents
  vec_latency_a: assert property ($rose(vecReq) |->
    !vecAck_ff ##1 !vecAck_ff ##1 vecAck_ff ##1 !vecAck_ff)
    else $error("vector answer not two cycles after take");
  vec_offset_a: assert property (vecAck_ff && !vecIsReset |->
    vecAddr_ff[7:0] inside {8'hf8, 8'hf6, 8'hf4, 8'hf2, 8'hdc, 8'hda,
    8'hd6, 8'h80}) else $error("vector offset not in table");
  reset_vec_a: assert property (vecAck_ff && vecIsReset &&
    !clkMonRst && !wdogRst |-> vecAddr_ff == 16'hfffe)
    else $error("plain reset vector wrong");
  trap_first_a: assert property (vecAck_ff && !vecIsReset &&
    $past(trapReq, 2) && $past(trapReq) |-> vecAddr_ff[7:0] == 8'hf8)
    else $error("trap did not win");
  spur_vec_a: assert property (vecAck_ff && !vecIsReset &&
    !$past(trapReq, 2) && !$past(swiReq, 2) && $past(iBit, 2) &&
    ($past(xBit, 2) || !$past(xirqReq, 2)) |->
    vecAddr_ff[7:0] == 8'h80) else $error("spurious vector missing");
  stop_wake_a: assert property (stopMode && !xirqReq && !irqReq &&
    uartReq == 4'h0 |=> !wakeStop_ff) else $error("false stop wake");
endmodule
bind cmvm_chip_mode_vector_map cmvm_props cmvm_props_inst (
  .clock, .rst, .bootModeSelect, .securedIn, .flashAccReq,
  .flashBlock_ff, .bdmActive_ff, .monitorRom_ff, .debugEn_ff, .vecReq,
  .vecIsReset, .vecAck_ff, .vecAddr_ff, .clkMonRst, .wdogRst, .trapReq,
  .swiReq, .xirqReq, .irqReq, .iBit, .xBit, .stopMode, .uartReq,
  .wakeStop_ff);

// ===== testbench.sv
// Purpose: self-checking bench for the chip mode and vector map
// Assumes: core model issues the vector fetches
// Notes:   rows hold fetch cases; mode, irq and wake tests follow
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [5:0]  req;  // trap swi xirq irq paOvf paEdge
    logic [3:0]  uart; // uart flags
    logic [1:0]  msk;  // iBit xBit
    logic [9:0]  en;   // enables register
    logic [2:0]  rcw;  // reset fetch, clkmon, wdog
    logic [15:0] exp;  // expected vector
  } cmvm_row_t;
  logic        clock = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0]  wb_adr_i = 0;
  logic [3:0]  wb_sel_i = 0, uartReq = 0, holdCyc = 0;
  logic [31:0] wb_dat_i = 0, q;
  logic        bootModeSelect = 1, debugPinIn = 1, clkMonRst = 0;
  logic        wdogRst = 0, securedIn = 0, flashAccReq = 0, iBit = 1;
  logic        xBit = 1, stopMode = 0, waitMode = 0, trapReq = 0;
  logic        swiReq = 0, xirqReq = 0, irqReq = 0, paOvfReq = 0;
  logic        paEdgeReq = 0, fetchGo = 0, fetchRst = 0;
  wire  [31:0] wb_dat_o;
  wire  [15:0] vecAddr_ff, gotAddr;
  wire         wb_ack_o, irqOut, flashBlock_ff, vecReq, vecIsReset;
  wire         vecAck_ff, bdmActive_ff, monitorRom_ff, debugEn_ff;
  wire         wakeStop_ff, wakeWait_ff, fetchDone;
  integer      n_errors = 0, compares = 0, k;
  cmvm_row_t   rows [0:17] = '{
    '{6'h3f, 4'hf, 2'b00, 10'h3ff, 3'b000, 16'h5af8},
    '{6'h1f, 4'h0, 2'b00, 10'h030, 3'b000, 16'h5af6},
    '{6'h0f, 4'h0, 2'b00, 10'h030, 3'b000, 16'h5af4},
    '{6'h0f, 4'h0, 2'b01, 10'h030, 3'b000, 16'h5af2},
    '{6'h03, 4'h4, 2'b00, 10'h130, 3'b000, 16'h5adc},
    '{6'h03, 4'h0, 2'b10, 10'h030, 3'b000, 16'h5a80},
    '{6'h03, 4'h4, 2'b00, 10'h120, 3'b000, 16'h5ada},
    '{6'h00, 4'h1, 2'b00, 10'h040, 3'b000, 16'h5ad6},
    '{6'h00, 4'h2, 2'b00, 10'h080, 3'b000, 16'h5ad6},
    '{6'h00, 4'h4, 2'b00, 10'h100, 3'b000, 16'h5ad6},
    '{6'h00, 4'h8, 2'b00, 10'h200, 3'b000, 16'h5ad6},
    '{6'h00, 4'hb, 2'b00, 10'h100, 3'b000, 16'h5a80},
    '{6'h00, 4'h0, 2'b11, 10'h000, 3'b100, 16'hfffe},
    '{6'h00, 4'h0, 2'b11, 10'h001, 3'b110, 16'hfffc},
    '{6'h00, 4'h0, 2'b11, 10'h000, 3'b110, 16'hfffe},
    '{6'h00, 4'h0, 2'b11, 10'h002, 3'b101, 16'hfffa},
    '{6'h00, 4'h0, 2'b11, 10'h000, 3'b101, 16'hfffe},
    '{6'h00, 4'h0, 2'b11, 10'h00f, 3'b111, 16'hfffc}};
  cmvm_chip_mode_vector_map #(.NSRC(7)) cmvm_chip_mode_vector_map_inst (
    .clock, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .irqOut, .bootModeSelect,
    .debugPinIn, .clkMonRst, .wdogRst, .securedIn, .flashAccReq,
    .flashBlock_ff, .iBit, .xBit, .stopMode, .waitMode, .vecReq,
    .vecIsReset, .vecAck_ff, .vecAddr_ff, .bdmActive_ff, .monitorRom_ff,
    .debugEn_ff, .wakeStop_ff, .wakeWait_ff, .trapReq, .swiReq, .xirqReq,
    .irqReq, .paOvfReq, .paEdgeReq, .uartReq);
  cmvm_core_model cmvm_core_model_inst (
    .clock, .rst, .fetchGo, .fetchRst, .holdCyc, .vecAck_ff, .vecAddr_ff,
    .vecReq_ff(vecReq), .vecIsReset_ff(vecIsReset),
    .gotAddr_ff(gotAddr), .fetchDone_ff(fetchDone));
  // =====================================================
  // clock, 10 ns period
  always #5 clock = ~clock;
  // =====================================================
  // verdict and end of run
  task report_and_stop;
    if (n_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // a wait that ran out ends the run as a failure
  task limit(input integer i, input integer n);
    if (i >= n) begin
      n_errors = n_errors + 1;
      report_and_stop;
    end
  endtask
  // classic single wishbone cycle, q taken at the ack edge
  task wbx(input logic [7:0] a, input logic w, input logic [31:0] d);
    integer i;
    begin
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      i = 0;
      do begin
        @(posedge clock);
        i = i + 1;
      end while (wb_ack_o !== 1'b1 && i < 20);
      limit(i, 20);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clock);
    end
  endtask
  // one vector fetch; v drops the trap request right at the take edge
  task fetch(input logic r, input logic v);
    integer i;
    begin
      fetchRst <= r;
      fetchGo  <= 1'b1;
      @(posedge clock);
      fetchGo  <= 1'b0;
      @(posedge clock);
      if (v)
        trapReq <= 1'b0;
      i = 0;
      do begin
        @(posedge clock);
        i = i + 1;
      end while (fetchDone !== 1'b1 && i < 40);
      limit(i, 40);
    end
  endtask
  // pin held from before release; reads wait for the mode filter
  task do_reset(input logic pin);
    bootModeSelect <= pin;
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (9) @(posedge clock);
  endtask
  // =====================================================
  // main sequence
  initial begin
    do_reset(1'b1);
    wbx(8'h00, 1'b1, 32'h0);
    wbx(8'h00, 1'b0, 32'h0);
    chk(q, 32'h9);
    chk({29'h0, bdmActive_ff, monitorRom_ff, debugEn_ff}, 32'h1);
    wbx(8'h04, 1'b0, 32'h0);
    chk(q, 32'hff);
    wbx(8'h08, 1'b0, 32'h0);
    chk(q, 32'h0);
    wbx(8'h04, 1'b1, 32'h5a);
    for (k = 0; k < 18; k = k + 1) begin
      wbx(8'h08, 1'b1, {22'h0, rows[k].en});
      {trapReq, swiReq, xirqReq, irqReq, paOvfReq, paEdgeReq} <= rows[k].req;
      uartReq <= rows[k].uart;
      {iBit, xBit} <= rows[k].msk;
      {clkMonRst, wdogRst} <= rows[k].rcw[1:0];
      fetch(rows[k].rcw[2], 1'b0);
      chk({16'h0, gotAddr}, {16'h0, rows[k].exp});
    end
    wbx(8'h14, 1'b0, 32'h0);
    chk(q, 32'hfffc);
    wbx(8'h0c, 1'b0, 32'h0);
    trapReq <= 1'b1;
    holdCyc <= 4'h3;
    fetch(1'b0, 1'b1);
    chk({16'h0, gotAddr}, 32'h5a80);
    chk({31'h0, irqOut}, 32'h0);
    wbx(8'h10, 1'b1, 32'h2);
    chk({31'h0, irqOut}, 32'h1);
    wbx(8'h0c, 1'b0, 32'h0);
    chk(q, 32'h3);
    chk({31'h0, irqOut}, 32'h0);
    wbx(8'h40, 1'b1, 32'hffffffff);
    wbx(8'h40, 1'b0, 32'h0);
    chk(q, 32'h0);
    wbx(8'h08, 1'b1, 32'h3f0);
    {iBit, stopMode, waitMode, paOvfReq, paEdgeReq} <= 5'h0f;
    repeat (3) @(posedge clock);
    chk({30'h0, wakeStop_ff, wakeWait_ff}, 32'h1);
    {paOvfReq, paEdgeReq, uartReq} <= 6'h01;
    repeat (3) @(posedge clock);
    chk({30'h0, wakeStop_ff, wakeWait_ff}, 32'h3);
    {stopMode, waitMode, securedIn} <= 3'b001;
    do_reset(1'b0);
    wbx(8'h00, 1'b0, 32'h0);
    chk(q, 32'he);
    chk({29'h0, bdmActive_ff, monitorRom_ff, debugEn_ff}, 32'h7);
    wbx(8'h00, 1'b1, 32'h1);
    wbx(8'h00, 1'b0, 32'h0);
    chk(q, 32'hd);
    chk({29'h0, bdmActive_ff, monitorRom_ff, debugEn_ff}, 32'h0);
    debugPinIn <= 1'b0;
    repeat (4) @(posedge clock);
    wbx(8'h00, 1'b0, 32'h0);
    chk(q, 32'h5);
    flashAccReq <= 1'b1;
    repeat (2) @(posedge clock);
    chk({31'h0, flashBlock_ff}, 32'h1);
    securedIn <= 1'b0;
    repeat (2) @(posedge clock);
    chk({31'h0, flashBlock_ff}, 32'h0);
    report_and_stop;
  end
endmodule
